// ### rtl/ddr2_init_pkg.sv
package ddr2_init_pkg;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CK_DIV         = 2;
    localparam int TICK_NS        = CLK_PERIOD_NS * CK_DIV;
    localparam int PWR_WAIT_NS    = 200000;
    localparam int CKE_WAIT_NS    = 400;
    localparam int RP_NS_DEF      = 15;
    localparam int RFC_NS_DEF     = 128;
    localparam int PWR_TICKS_DEF  = (PWR_WAIT_NS + TICK_NS - 1) / TICK_NS;
    localparam int CKE_TICKS      = (CKE_WAIT_NS + TICK_NS - 1) / TICK_NS;
    localparam int RP_TICKS_DEF   = (RP_NS_DEF + TICK_NS - 1) / TICK_NS;
    localparam int RFC_TICKS_DEF  = (RFC_NS_DEF + TICK_NS - 1) / TICK_NS;
    localparam int MRD_TICKS_DEF  = 2;
    localparam int DLL_LOCK_CK    = 200;
    localparam int ODT_HOLD_CK    = 8;
    localparam int ADDR_W_DEF     = 14;
    localparam int WAIT_W         = 16;

    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_MR     = 4'h4;
    localparam logic [3:0] OFS_EMR    = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_HOT_BIT    = 1;
    localparam int CTRL_ODT_BIT    = 2;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_READY_BIT  = 1;
    localparam int STAT_STATE_LSB  = 4;

    localparam int MODE_W            = 13;
    localparam int BIT_DLL_OFF       = 0;
    localparam int BIT_ODT_LO        = 2;
    localparam int BIT_ODT_HI        = 6;
    localparam int BIT_REFRESH_RATE  = 7;
    localparam int BIT_DLL_RESET     = 8;
    localparam int BIT_PRE_ALL       = 10;
    localparam int CAL_LSB           = 7;
    localparam int CAL_W             = 3;
    localparam logic [12:0] MR_RESET  = 13'h0000;
    localparam logic [12:0] EMR_RESET = 13'h0000;

    localparam logic [2:0] BA_MAIN      = 3'h0;
    localparam logic [2:0] BA_EXT_ONE   = 3'h1;
    localparam logic [2:0] BA_EXT_TWO   = 3'h2;
    localparam logic [2:0] BA_EXT_THREE = 3'h3;

    typedef logic [3:0] cmd_t;
    localparam cmd_t CMD_LOAD      = 4'h0;
    localparam cmd_t CMD_REFRESH   = 4'h1;
    localparam cmd_t CMD_PRECHARGE = 4'h2;
    localparam cmd_t CMD_NOP       = 4'h7;
    localparam cmd_t CMD_DESELECT  = 4'hF;

    typedef enum logic [3:0] {
        ST_IDLE, ST_POWER, ST_PRE_ONE, ST_EXT_TWO, ST_EXT_THREE, ST_DLL_ON, ST_DLL_RESET,
        ST_PRE_TWO, ST_REF_ONE, ST_REF_TWO, ST_MAIN_OP, ST_CAL_DEFAULT, ST_CAL_EXIT,
        ST_LOCK, ST_DONE
    } init_state_t;
endpackage

// ### rtl/sdram_init_ext_mode_seq.sv
// Operation
// R1: set refresh-rate bit when case runs hot
// R2: other second-register bits written zero
// R3: load second register idle, then load delay
// R4: load third register idle, then load delay
// R5: third register written all zeros
// R6: memory keeps register values across reloads
// R7: bit sixteen and bits above twelve zero
// R8: only nop for power wait, then raise enable
// R9: clock enable stays high through sequence
// R10: wait 400ns after enable, then precharge all
// R11: second register load with bank code two
// R12: third register load with bank code three
// R13: first register load enables loop, calibration zero
// R14: main register load with loop reset bit
// R15: precharge all then two refreshes
// R16: main register load without loop reset
// R17: first register load with calibration bits set
// R18: first register reload with calibration bits cleared
// R19: ready only 200 clocks after loop reset
// R20: address ten precharges all, banks select register
// R21: termination pin low before and during init
// R22: termination pin low eight clocks after enable
// R23: loop enable followed by reset, 200 clock wait
// R24: steps strictly ordered with nop waits
// R25: times rounded up to whole clock cycles
module sdram_init_ext_mode_seq #(
    parameter int ADDR_W    = ddr2_init_pkg::ADDR_W_DEF,
    parameter int PWR_TICKS = ddr2_init_pkg::PWR_TICKS_DEF,
    parameter int MRD_TICKS = ddr2_init_pkg::MRD_TICKS_DEF,
    parameter int RP_TICKS  = ddr2_init_pkg::RP_TICKS_DEF,
    parameter int RFC_TICKS = ddr2_init_pkg::RFC_TICKS_DEF
) (
    input  wire logic              CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic [3:0]        ADR_I,
    input  wire logic [31:0]       DAT_I,
    output logic      [31:0]       DAT_O,
    input  wire logic [3:0]        SEL_I,
    input  wire logic              WE_I,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    output logic                   ACK_O,
    output logic                   CK_O,
    output logic                   CK_N_O,
    output logic                   CKE_O,
    output logic                   CS_N_O,
    output logic                   RAS_N_O,
    output logic                   CAS_N_O,
    output logic                   WE_N_O,
    output logic      [2:0]        BA_O,
    output logic      [ADDR_W-1:0] ADDR_O,
    output logic                   ODT_O,
    output logic                   READY_O
);
    import ddr2_init_pkg::*;

    if (ADDR_W < MODE_W || PWR_TICKS < 1 || PWR_TICKS >= (1 << WAIT_W) || MRD_TICKS < 1 ||
        MRD_TICKS >= (1 << WAIT_W) || RP_TICKS < 1 || RP_TICKS >= (1 << WAIT_W) || RFC_TICKS < 1 ||
        RFC_TICKS >= (1 << WAIT_W) || CK_DIV < 2 || CK_DIV > 16 || CK_DIV % 2 != 0) begin : g_param_check
        $error("sdram_init_ext_mode_seq: unsupported parameter values");
    end

    // memory clock divider; commands change as the memory clock falls
    logic [3:0]           div_cnt_reg;
    logic                 ck_reg;
    wire logic            tick = (div_cnt_reg == 4'(CK_DIV - 1));

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            div_cnt_reg <= 4'h0;
            ck_reg      <= 1'b0;
        end else begin
            div_cnt_reg <= tick ? 4'h0 : div_cnt_reg + 4'h1;
            ck_reg      <= tick ? 1'b0 : (div_cnt_reg == 4'(CK_DIV / 2 - 1)) ? 1'b1 : ck_reg;
        end
    end

    // wishbone slave
    logic                 ack_reg;
    logic [31:0]          dat_reg;
    logic                 hot_reg;
    logic                 odt_req_reg;
    logic [MODE_W-1:0]    mr_val_reg;
    logic [MODE_W-1:0]    emr_val_reg;
    init_state_t          state_reg;
    init_state_t          state_next;

    wire logic            wb_req    = CYC_I && STB_I && !ack_reg;
    wire logic            wb_wr     = wb_req && WE_I;
    wire logic            sel_ctrl  = (ADR_I == OFS_CTRL);
    wire logic            sel_mr    = (ADR_I == OFS_MR);
    wire logic            sel_emr   = (ADR_I == OFS_EMR);
    wire logic            sel_stat  = (ADR_I == OFS_STATUS);
    wire logic            busy      = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
    wire logic            start_acc = wb_wr && sel_ctrl && SEL_I[0] && DAT_I[CTRL_START_BIT] && !busy;
    wire logic [31:0]     ctrl_rd   = {29'h0, odt_req_reg, hot_reg, 1'b0};
    wire logic [31:0]     stat_rd   = {24'h0, state_reg, 2'h0, (state_reg == ST_DONE), busy};
    wire logic [31:0]     mr_rd     = {19'h0, mr_val_reg};
    wire logic [31:0]     emr_rd    = {19'h0, emr_val_reg};
    wire logic [31:0]     rd_mux    = sel_ctrl ? ctrl_rd : sel_mr ? mr_rd : sel_emr ? emr_rd :
                                      sel_stat ? stat_rd : 32'h0000_0000;

    // mode values are only taken on software writes; a load mid-sequence uses the latest value
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h0000_0000;
            hot_reg     <= 1'b0;
            odt_req_reg <= 1'b0;
            mr_val_reg  <= MR_RESET;
            emr_val_reg <= EMR_RESET;
        end else begin
            ack_reg <= wb_req;
            dat_reg <= wb_req ? rd_mux : dat_reg;
            if (wb_wr && sel_ctrl && SEL_I[0]) begin
                hot_reg     <= DAT_I[CTRL_HOT_BIT];
                odt_req_reg <= DAT_I[CTRL_ODT_BIT];
            end
            if (wb_wr && sel_mr && SEL_I[0])
                mr_val_reg[7:0] <= DAT_I[7:0];
            if (wb_wr && sel_mr && SEL_I[1])
                mr_val_reg[MODE_W-1:8] <= DAT_I[MODE_W-1:8];
            if (wb_wr && sel_emr && SEL_I[0])
                emr_val_reg[7:0] <= DAT_I[7:0];
            if (wb_wr && sel_emr && SEL_I[1])
                emr_val_reg[MODE_W-1:8] <= DAT_I[MODE_W-1:8];
        end
    end

    // sequence table
    logic [WAIT_W-1:0]    wait_cnt_reg;
    logic [7:0]           dll_cnt_reg;
    logic [3:0]           odt_hold_reg;
    cmd_t                 cmd_sel;
    logic [2:0]           ba_sel;
    logic [MODE_W-1:0]    addr_sel;
    logic [WAIT_W-1:0]    wait_sel;

    wire logic            dll_locked = (dll_cnt_reg == 8'(DLL_LOCK_CK));
    wire logic            wait_done  = (wait_cnt_reg == '0);
    wire logic            issue      = tick && busy && wait_done && (state_reg != ST_LOCK || dll_locked);
    wire logic [MODE_W-1:0] main_op  = mr_val_reg & ~(MODE_W'(1) << BIT_DLL_RESET);
    wire logic [MODE_W-1:0] ext_keep = emr_val_reg & ~(MODE_W'(1) << BIT_DLL_OFF) &
                                       ~(MODE_W'(7) << CAL_LSB);
    wire logic            odt_on_load = issue && (cmd_sel == CMD_LOAD) && (ba_sel == BA_EXT_ONE) &&
                                        (addr_sel[BIT_ODT_LO] || addr_sel[BIT_ODT_HI]);

    always_comb begin
        cmd_sel    = CMD_NOP;
        ba_sel     = BA_MAIN;
        addr_sel   = '0;
        wait_sel   = WAIT_W'(MRD_TICKS - 1);
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                cmd_sel = CMD_DESELECT;
            end
            ST_POWER: begin
                wait_sel   = WAIT_W'(CKE_TICKS - 1); // see R10 see R25
                state_next = ST_PRE_ONE;
            end
            ST_PRE_ONE: begin
                cmd_sel               = CMD_PRECHARGE;
                addr_sel[BIT_PRE_ALL] = 1'b1; // see R20
                wait_sel              = WAIT_W'(RP_TICKS - 1);
                state_next            = ST_EXT_TWO;
            end
            ST_EXT_TWO: begin
                cmd_sel                    = CMD_LOAD;
                ba_sel                     = BA_EXT_TWO; // see R11
                addr_sel[BIT_REFRESH_RATE] = hot_reg; // see R1 see R2
                state_next                 = ST_EXT_THREE;
            end
            ST_EXT_THREE: begin
                cmd_sel    = CMD_LOAD;
                ba_sel     = BA_EXT_THREE; // see R12 see R5
                state_next = ST_DLL_ON;
            end
            ST_DLL_ON: begin
                cmd_sel    = CMD_LOAD;
                ba_sel     = BA_EXT_ONE; // see R13
                state_next = ST_DLL_RESET;
            end
            ST_DLL_RESET: begin
                cmd_sel                 = CMD_LOAD;
                addr_sel[BIT_DLL_RESET] = 1'b1; // see R14 see R23
                state_next              = ST_PRE_TWO;
            end
            ST_PRE_TWO: begin
                cmd_sel               = CMD_PRECHARGE;
                addr_sel[BIT_PRE_ALL] = 1'b1; // see R15
                wait_sel              = WAIT_W'(RP_TICKS - 1);
                state_next            = ST_REF_ONE;
            end
            ST_REF_ONE: begin
                cmd_sel    = CMD_REFRESH;
                wait_sel   = WAIT_W'(RFC_TICKS - 1);
                state_next = ST_REF_TWO;
            end
            ST_REF_TWO: begin
                cmd_sel    = CMD_REFRESH; // see R15
                wait_sel   = WAIT_W'(RFC_TICKS - 1);
                state_next = ST_MAIN_OP;
            end
            ST_MAIN_OP: begin
                cmd_sel    = CMD_LOAD;
                addr_sel   = main_op; // see R16
                state_next = ST_CAL_DEFAULT;
            end
            ST_CAL_DEFAULT: begin
                cmd_sel    = CMD_LOAD;
                ba_sel     = BA_EXT_ONE;
                addr_sel   = ext_keep | (MODE_W'(7) << CAL_LSB); // see R17
                state_next = ST_CAL_EXIT;
            end
            ST_CAL_EXIT: begin
                cmd_sel    = CMD_LOAD;
                ba_sel     = BA_EXT_ONE;
                addr_sel   = ext_keep; // see R18
                state_next = ST_LOCK;
            end
            ST_LOCK: begin
                state_next = ST_DONE; // see R19
            end
            ST_DONE: begin
                state_next = ST_DONE;
            end
        endcase
    end

    // pin registers; bits above twelve and bank bit two never driven high
    logic                 cke_reg;
    logic                 odt_reg;
    cmd_t                 cmd_reg;
    logic [2:0]           ba_reg;
    logic [ADDR_W-1:0]    addr_reg;
    wire cmd_t            cmd_out = (issue && state_reg != ST_LOCK) ? cmd_sel :
                                    (state_reg == ST_IDLE) ? CMD_DESELECT : CMD_NOP;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg    <= ST_IDLE;
            wait_cnt_reg <= '0;
            cke_reg      <= 1'b0;
            cmd_reg      <= CMD_DESELECT;
            ba_reg       <= BA_MAIN;
            addr_reg     <= '0;
        end else if (start_acc) begin
            state_reg    <= ST_POWER;
            wait_cnt_reg <= WAIT_W'(PWR_TICKS - 1); // see R8
            cke_reg      <= 1'b0;
        end else if (tick) begin
            cmd_reg      <= cmd_out; // see R24
            ba_reg       <= issue ? ba_sel : BA_MAIN; // see R20
            addr_reg     <= issue ? ADDR_W'(addr_sel) : '0; // see R7
            if (issue) begin
                state_reg    <= state_next;
                wait_cnt_reg <= wait_sel; // see R3 see R4
                cke_reg      <= cke_reg || (state_reg == ST_POWER); // see R9
            end else if (!wait_done) begin
                wait_cnt_reg <= wait_cnt_reg - WAIT_W'(1);
            end
        end
    end

    // loop lock counter and termination gating
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dll_cnt_reg  <= 8'h00;
            odt_hold_reg <= 4'h0;
            odt_reg      <= 1'b0;
        end else if (tick) begin
            if (issue && state_reg == ST_DLL_RESET)
                dll_cnt_reg <= 8'h00; // see R23
            else if (!dll_locked)
                dll_cnt_reg <= dll_cnt_reg + 8'h01;
            if (odt_on_load)
                odt_hold_reg <= 4'(ODT_HOLD_CK); // see R22
            else if (odt_hold_reg != 4'h0)
                odt_hold_reg <= odt_hold_reg - 4'h1;
            // termination only after init; a restart drops it at once
            odt_reg <= odt_req_reg && (state_reg == ST_DONE) && (odt_hold_reg == 4'h0) &&
                       !odt_on_load && !start_acc; // see R21
        end else if (start_acc) begin
            odt_reg <= 1'b0;
        end
    end

    assign DAT_O   = dat_reg;
    assign ACK_O   = ack_reg;
    assign CK_O    = ck_reg;
    assign CK_N_O  = ~ck_reg;
    assign CKE_O   = cke_reg;
    assign CS_N_O  = cmd_reg[3];
    assign RAS_N_O = cmd_reg[2];
    assign CAS_N_O = cmd_reg[1];
    assign WE_N_O  = cmd_reg[0];
    assign BA_O    = ba_reg;
    assign ADDR_O  = addr_reg;
    assign ODT_O   = odt_reg;
    assign READY_O = (state_reg == ST_DONE);

    // checking helpers: ticks since last real command
    logic [WAIT_W-1:0]    gap_cnt_reg;
    logic                 last_load_reg;
    wire logic            real_cmd = tick && issue && state_reg != ST_LOCK;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gap_cnt_reg   <= '0;
            last_load_reg <= 1'b0;
        end else if (real_cmd) begin
            gap_cnt_reg   <= '0;
            last_load_reg <= (cmd_sel == CMD_LOAD);
        end else if (tick && gap_cnt_reg != '1) begin
            gap_cnt_reg <= gap_cnt_reg + WAIT_W'(1);
        end
    end

    property p_load_gap;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (real_cmd && last_load_reg) |-> (gap_cnt_reg >= WAIT_W'(MRD_TICKS - 1));
    endproperty
    a_load_gap: assert property (p_load_gap) else $error("command too soon after load"); // see R3

    property p_cke_hold;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (cke_reg && busy && !start_acc) |=> cke_reg;
    endproperty
    a_cke_hold: assert property (p_cke_hold) else $error("clock enable fell during init"); // see R9

    property p_nop_before_cke;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        !cke_reg |-> (cmd_reg == CMD_NOP || cmd_reg == CMD_DESELECT);
    endproperty
    a_nop_before_cke: assert property (p_nop_before_cke) else $error("command with enable low"); // see R8

    property p_ext_two_bits;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (cmd_reg == CMD_LOAD && ba_reg == BA_EXT_TWO) |->
            ((addr_reg & ~(ADDR_W'(1) << BIT_REFRESH_RATE)) == '0) && (addr_reg[BIT_REFRESH_RATE] == hot_reg);
    endproperty
    a_ext_two_bits: assert property (p_ext_two_bits) else $error("second register bits wrong"); // see R2

    property p_ext_three_zero;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (cmd_reg == CMD_LOAD && ba_reg == BA_EXT_THREE) |-> (addr_reg == '0);
    endproperty
    a_ext_three_zero: assert property (p_ext_three_zero) else $error("third register not zero"); // see R5

    property p_pre_all;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (cmd_reg == CMD_PRECHARGE) |-> addr_reg[BIT_PRE_ALL];
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge without all-banks bit"); // see R20

    property p_high_bits_zero;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        1'b1 |-> (ba_reg[2] == 1'b0) && ((addr_reg >> MODE_W) == '0);
    endproperty
    a_high_bits_zero: assert property (p_high_bits_zero) else $error("reserved high bit driven"); // see R7

    property p_cal_default;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (issue && state_reg == ST_CAL_DEFAULT) |=> ##[0:2] (addr_reg[CAL_LSB+:CAL_W] == 3'h7);
    endproperty
    a_cal_default: assert property (p_cal_default) else $error("calibration default not set"); // see R17

    property p_ready_lock;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        $rose(READY_O) |-> dll_locked && $past(dll_locked);
    endproperty
    a_ready_lock: assert property (p_ready_lock) else $error("ready before loop locked"); // see R19

    property p_odt_low_busy;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (busy || odt_hold_reg != 4'h0) |-> !ODT_O;
    endproperty
    a_odt_low_busy: assert property (p_odt_low_busy) else $error("termination high too early"); // see R21

    c_done:     cover property (@(posedge CLK_I) disable iff (!RESET_N_I) $rose(READY_O));
    c_hot_load: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
                               cmd_reg == CMD_LOAD && ba_reg == BA_EXT_TWO && addr_reg[BIT_REFRESH_RATE]);
    c_refresh:  cover property (@(posedge CLK_I) disable iff (!RESET_N_I) cmd_reg == CMD_REFRESH);
    c_odt_on:   cover property (@(posedge CLK_I) disable iff (!RESET_N_I) $rose(ODT_O));
endmodule

// ### tb/ddr2_mem_model.sv
module ddr2_mem_model #(
    parameter int ADDR_W = 14
) (
    input  wire logic              ck_i,
    input  wire logic              cke_i,
    input  wire logic [3:0]        cmd_i,
    input  wire logic [2:0]        ba_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              odt_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import ddr2_init_pkg::*;
    logic [12:0] mode_regs [0:3];
    logic [20:0] log_q [$];
    int          pwr_nops;
    int          cke_drops;
    int          since_cke;
    int          pre_gap;
    int          odt_highs;
    int          since_cmd;
    int          mrd_short;
    logic        last_load;
    logic        cke_up;
    time         dll_t;
    // mode registers survive a restart, only the trace is wiped
    task automatic clear();
        log_q.delete();
        pwr_nops = 0;
        cke_drops = 0;
        pre_gap = -1;
        odt_highs = 0;
        since_cmd = 0;
        mrd_short = 0;
        last_load = 0;
        cke_up = 0;
    endtask
    initial clear();
    always @(posedge ck_i) begin
        if (!cke_i) begin
            if (cke_up) cke_drops++;
            else if (cmd_i == CMD_NOP || cmd_i == CMD_DESELECT) pwr_nops++;
        end else if (!cke_up && pwr_nops > 0) begin
            cke_up = 1;
            since_cke = 0;
        end else begin
            since_cke++;
        end
        if (odt_i) odt_highs++;
        since_cmd++;
        if (cmd_i != CMD_NOP && cmd_i != CMD_DESELECT) begin
            if (last_load && since_cmd < MRD_TICKS_DEF) mrd_short++;
            since_cmd = 0;
            last_load = (cmd_i == CMD_LOAD);
            log_q.push_back({cmd_i, ba_i, 14'(addr_i)});
            if (cmd_i == CMD_PRECHARGE && pre_gap < 0) pre_gap = since_cke;
            if (cmd_i == CMD_LOAD) mode_regs[ba_i[1:0]] = addr_i[12:0];
            if (cmd_i == CMD_LOAD && ba_i == BA_MAIN && addr_i[BIT_DLL_RESET]) dll_t = $time;
        end
    end
endmodule

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ddr2_init_pkg::*;
    localparam int PT = 10;
    logic        clk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, rd;
    logic        ack, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, termination_control, ready;
    logic [2:0]  ba;
    logic [13:0] addr;
    int          errors = 0, tests_run = 0;
    integer      seed = 32'hd6432884;
    logic [20:0] exp_q [$];
    always #25 clk = ~clk;
    sdram_init_ext_mode_seq #(.PWR_TICKS(PT)) i_sdram_init_ext_mode_seq (.CLK_I(clk), .RESET_N_I(rst_n),
        .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
        .CK_O(ck), .CK_N_O(ck_n), .CKE_O(cke), .CS_N_O(cs_n), .RAS_N_O(ras_n), .CAS_N_O(cas_n), .WE_N_O(we_n),
        .BA_O(ba), .ADDR_O(addr), .ODT_O(termination_control), .READY_O(ready));
    ddr2_mem_model #(.ADDR_W(14)) i_ddr2_mem_model (.ck_i(ck), .cke_i(cke), .cmd_i({cs_n, ras_n, cas_n, we_n}),
        .ba_i(ba), .addr_i(addr), .odt_i(termination_control));
    task automatic conclude();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until ack is sampled, then released for one cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            conclude();
        end
        r = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task automatic run(input logic hot, input logic odt_req);
        logic [12:0] mr, ext_cfg_reg_one;
        logic [20:0] g, x;
        int          i;
        mr = 13'($random(seed));
        ext_cfg_reg_one = 13'($random(seed));
        if (odt_req) ext_cfg_reg_one[BIT_ODT_LO] = 1'b1;
        exp_q = '{{CMD_PRECHARGE, 17'h00400}, {CMD_LOAD, BA_EXT_TWO, 6'h0, hot, 7'h0},
            {CMD_LOAD, BA_EXT_THREE, 14'h0}, {CMD_LOAD, BA_EXT_ONE, 14'h0}, {CMD_LOAD, BA_MAIN, 14'h0100},
            {CMD_PRECHARGE, 17'h00400}, {CMD_REFRESH, 17'h0}, {CMD_REFRESH, 17'h0},
            {CMD_LOAD, BA_MAIN, 1'b0, mr & 13'h1EFF}, {CMD_LOAD, BA_EXT_ONE, 1'b0, (ext_cfg_reg_one & 13'h1C7E) | 13'h0380},
            {CMD_LOAD, BA_EXT_ONE, 1'b0, ext_cfg_reg_one & 13'h1C7E}};
        wb(1, OFS_MR, {19'h0, mr}, rd);
        wb(1, OFS_EMR, {19'h0, ext_cfg_reg_one}, rd);
        i_ddr2_mem_model.clear();
        wb(1, OFS_CTRL, {29'h0, odt_req, hot, 1'b1}, rd);
        wb(0, OFS_STATUS, 32'h0, rd);
        chk(rd[STAT_BUSY_BIT], 1);
        chk(ready, 0);
        i = 0;
        while (ready !== 1'b1 && i < 5000) begin
            @(posedge clk);
            i++;
        end
        if (i >= 5000) begin
            errors++;
            conclude();
        end
        chk(($time - i_ddr2_mem_model.dll_t) >= DLL_LOCK_CK * TICK_NS, 1);
        chk(i_ddr2_mem_model.log_q.size(), exp_q.size());
        foreach (exp_q[k]) begin
            g = i_ddr2_mem_model.log_q[k];
            x = exp_q[k];
            if (x[20:17] != CMD_LOAD) begin
                g &= 21'h1E0400;
                x &= 21'h1E0400;
            end
            chk(g, x);
        end
        chk(i_ddr2_mem_model.pwr_nops >= PT, 1);
        chk(i_ddr2_mem_model.cke_drops, 0);
        chk(i_ddr2_mem_model.pre_gap >= CKE_TICKS, 1);
        chk(i_ddr2_mem_model.mrd_short, 0);
        chk(i_ddr2_mem_model.odt_highs, 0);
        chk(i_ddr2_mem_model.mode_regs[2], {5'h0, hot, 7'h0});
        chk(i_ddr2_mem_model.mode_regs[3], 0);
        wb(0, OFS_STATUS, 32'h0, rd);
        chk(rd & 32'hF3, 32'hE2);
        repeat (20) @(posedge clk);
        chk(termination_control, odt_req);
        $display("init run hot=%0d odt=%0d done", hot, odt_req);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        wb(1, 4'h6, 32'hFFFFFFFF, rd);
        wb(0, 4'h6, 32'h0, rd);
        chk(rd, 0);
        chk(cke, 0);
        chk(ck ^ ck_n, 1);
        $display("unmapped access done");
        for (int r = 0; r < 3; r++) begin
            run(r[0], r[1]);
        end
        conclude();
    end
endmodule
